// file: core/fpeg_guard.sv
// Flash program/erase guard: key lock, store control, timed write/erase, page security.
// Assumes the core stalls while stall_o is high and holds requests one cycle each.
`timescale 1ns/1ns
module fpeg_guard #(
  parameter int ERASE_CYCLES = fpeg_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  // Core register writes
  input  wire logic                        key_wr_i,
  input  wire logic [7:0]                  key_data_i,
  input  wire logic                        ctrl_wr_i,
  input  wire logic [1:0]                  ctrl_data_i,
  // Core memory traffic
  input  wire fpeg_pkg::fpeg_xreq_type     xreq_i,
  input  wire logic                        code_rd_i,
  input  wire logic [fpeg_pkg::ADDR_W-1:0] code_addr_i,
  input  wire logic [fpeg_pkg::ADDR_W-1:0] exec_addr_i,
  output logic      [7:0]                  code_data_o,
  output logic                             external_data_ram_wr_o,
  output logic                             external_data_ram_rd_o,
  // Debug port
  input  wire fpeg_pkg::fpeg_dreq_type     dreq_i,
  output logic      [7:0]                  dbg_data_o,
  // Supply monitor state, from another domain
  input  wire logic                        vdd_mon_en_i,
  input  wire logic                        vdd_rst_sel_i,
  // Status
  output logic      [1:0]                  store_control_register_o,
  output logic                             key_open_o,
  output logic                             key_barred_o,
  output logic                             stall_o,
  output logic                             flash_error_reset_o,
  output logic                             flash_error_flag_o
);
  fpeg_pkg::fpeg_key_type key_reg, key_next;
  fpeg_pkg::fpeg_op_type  op_reg, op_next;
  logic [1:0]                  ctrl_reg;
  logic [fpeg_pkg::CNT_W-1:0]  cnt_reg;
  logic [fpeg_pkg::ADDR_W-1:0] addr_reg;
  logic [8:0]                  idx_reg;
  logic [7:0]                  data_reg;
  logic [7:0]                  lock_reg;
  logic                        lock_load_reg;
  logic                        err_reg;
  logic                        flag_reg;
  logic                        phase_reg;
  logic [1:0]                  vdd_s1_reg, vdd_s2_reg;
  logic                        lock_take_reg;
  logic                        dbg_rd_reg;
  logic                        dbg_deny_reg;
  logic [7:0]                  store_rdata;

  function automatic logic [4:0] page_of(input logic [fpeg_pkg::ADDR_W-1:0] a);
    page_of = a[fpeg_pkg::PAGE_MSB:fpeg_pkg::PAGE_LSB];
  endfunction

  function automatic logic page_locked(input logic [4:0] p, input logic [7:0] lb);
    logic [7:0] n;
    n = ~lb;
    page_locked = ({3'h0, p} < n) || (n != 8'h00 && p == fpeg_pkg::LOCK_BYTE_PAGE);
  endfunction

  // The reserved top page and anything past it sit outside user space
  function automatic logic above_user(input logic [fpeg_pkg::ADDR_W-1:0] a);
    above_user = a > fpeg_pkg::USER_TOP;
  endfunction

  // Decoding
  wire        we_bit     = ctrl_reg[fpeg_pkg::WSEL_BIT];
  wire        ee_bit     = ctrl_reg[fpeg_pkg::ESEL_BIT];
  wire        idle       = (op_reg == fpeg_pkg::FPEG_OP_IDLE);
  wire        flash_mv   = xreq_i.wr && we_bit && idle;
  wire        exec_lock  = page_locked(page_of(exec_addr_i), lock_reg);
  wire        x_above    = above_user(xreq_i.addr);
  wire        x_locked   = page_locked(page_of(xreq_i.addr), lock_reg);
  wire        x_lbpage   = page_of(xreq_i.addr) == fpeg_pkg::LOCK_BYTE_PAGE;
  // Firmware may never erase the lock byte page, locked or not
  wire        fw_deny    = x_above || (x_locked && !exec_lock) || (ee_bit && x_lbpage);
  wire        vdd_ok     = vdd_s2_reg[0] && vdd_s2_reg[1];
  wire        unlocked   = (key_reg == fpeg_pkg::FPEG_KEY_OPEN);
  wire        fw_err     = flash_mv && (fw_deny || !vdd_ok);
  wire        fw_go      = flash_mv && !fw_err && unlocked;
  wire        c_above    = above_user(code_addr_i);
  wire        c_deny     = code_rd_i && (c_above ||
                           (page_locked(page_of(code_addr_i), lock_reg) && !exec_lock));
  wire        d_deny     = above_user(dreq_i.addr) ||
                           page_locked(page_of(dreq_i.addr), lock_reg);
  wire        d_go       = (dreq_i.wr || dreq_i.erase) && !d_deny && idle
                           && !flash_mv;
  wire        counting   = !idle && (cnt_reg != '0);
  wire        phase_wr   = !idle && !counting && phase_reg;
  wire        mem_we     = phase_wr;
  wire [7:0]  mem_wdata  = (op_reg == fpeg_pkg::FPEG_OP_ERASE) ? fpeg_pkg::ERASED_BYTE
                           : (store_rdata & data_reg);
  wire [fpeg_pkg::ADDR_W-1:0] erase_addr = {addr_reg[fpeg_pkg::PAGE_MSB:fpeg_pkg::PAGE_LSB],
                                            idx_reg};
  wire [fpeg_pkg::ADDR_W-1:0] mem_waddr  = (op_reg == fpeg_pkg::FPEG_OP_ERASE) ? erase_addr
                                           : addr_reg;
  wire [fpeg_pkg::ADDR_W-1:0] mem_raddr  = !idle ? addr_reg
                                           : (lock_load_reg ? fpeg_pkg::LOCK_BYTE_ADDR
                                           : (dreq_i.rd ? dreq_i.addr : code_addr_i));

  fpeg_store u_store (
    .clock_i (clock_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (store_rdata)
  );

  // Key sequence
  // Barred is a sink: only reset leaves it, so a stray key byte costs a reset
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      fpeg_pkg::FPEG_KEY_IDLE: begin
        if (key_wr_i) begin
          key_next = (key_data_i == fpeg_pkg::KEY_FIRST) ? fpeg_pkg::FPEG_KEY_HALF
                     : fpeg_pkg::FPEG_KEY_BARRED;
        end else if (flash_mv && !fw_err) begin
          key_next = fpeg_pkg::FPEG_KEY_BARRED;
        end
      end
      fpeg_pkg::FPEG_KEY_HALF: begin
        if (key_wr_i) begin
          key_next = (key_data_i == fpeg_pkg::KEY_SECOND) ? fpeg_pkg::FPEG_KEY_OPEN
                     : fpeg_pkg::FPEG_KEY_BARRED;
        end else if (flash_mv && !fw_err) begin
          key_next = fpeg_pkg::FPEG_KEY_BARRED;
        end
      end
      fpeg_pkg::FPEG_KEY_OPEN: begin
        if (key_wr_i) begin
          key_next = fpeg_pkg::FPEG_KEY_BARRED;
        end else if (fw_go) begin
          key_next = fpeg_pkg::FPEG_KEY_IDLE;
        end
      end
      default: key_next = fpeg_pkg::FPEG_KEY_BARRED;
    endcase
  end

  // Operation sequencer: count the cell time, then commit bytes
  // An erase commits one byte a cycle, so it stalls a page length past its cell time
  always_comb begin
    op_next = op_reg;
    case (op_reg)
      fpeg_pkg::FPEG_OP_IDLE: begin
        if (fw_go) begin
          op_next = ee_bit ? fpeg_pkg::FPEG_OP_ERASE : fpeg_pkg::FPEG_OP_WRITE;
        end else if (d_go) begin
          op_next = dreq_i.erase ? fpeg_pkg::FPEG_OP_ERASE : fpeg_pkg::FPEG_OP_WRITE;
        end
      end
      fpeg_pkg::FPEG_OP_WRITE: begin
        if (phase_wr) begin
          op_next = fpeg_pkg::FPEG_OP_IDLE;
        end
      end
      fpeg_pkg::FPEG_OP_ERASE: begin
        if (phase_wr && idx_reg == 9'(fpeg_pkg::PAGE_BYTES - 1)) begin
          op_next = fpeg_pkg::FPEG_OP_IDLE;
        end
      end
      default: op_next = fpeg_pkg::FPEG_OP_IDLE;
    endcase
  end

  // Supply monitor levels cross from another domain
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vdd_s1_reg <= 2'h0;
      vdd_s2_reg <= 2'h0;
    end else begin
      vdd_s1_reg <= {vdd_rst_sel_i, vdd_mon_en_i};
      vdd_s2_reg <= vdd_s1_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_reg <= fpeg_pkg::FPEG_KEY_IDLE;
      op_reg  <= fpeg_pkg::FPEG_OP_IDLE;
    end else begin
      key_reg <= key_next;
      op_reg  <= op_next;
    end
  end

  // Store control bits stay until software changes them
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= fpeg_pkg::STORE_CTRL_RESET;
    end else if (ctrl_wr_i) begin
      ctrl_reg <= ctrl_data_i;
    end
  end

  // Timer and address capture; timing is fixed so no polling is needed
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg   <= '0;
      addr_reg  <= '0;
      data_reg  <= 8'h00;
      idx_reg   <= 9'h000;
      phase_reg <= 1'b0;
    end else if (idle && op_next != fpeg_pkg::FPEG_OP_IDLE) begin
      addr_reg  <= fw_go ? xreq_i.addr : dreq_i.addr;
      data_reg  <= fw_go ? xreq_i.data : dreq_i.data;
      cnt_reg   <= (op_next == fpeg_pkg::FPEG_OP_ERASE) ? fpeg_pkg::CNT_W'(ERASE_CYCLES)
                   : fpeg_pkg::CNT_W'(fpeg_pkg::WRITE_CYCLES);
      idx_reg   <= 9'h000;
      phase_reg <= 1'b0;
    end else if (counting) begin
      cnt_reg   <= cnt_reg - 1'b1;
      phase_reg <= 1'b1;
    end else if (phase_wr) begin
      idx_reg   <= idx_reg + 1'b1;
    end
  end

  // Lock byte sampled once after reset release; later edits wait for the next reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_reg      <= fpeg_pkg::LOCK_BYTE_RESET;
      lock_load_reg <= 1'b1;
      lock_take_reg <= 1'b0;
    end else begin
      lock_load_reg <= 1'b0;
      lock_take_reg <= lock_load_reg;
      if (lock_take_reg) begin
        lock_reg <= store_rdata;
      end
    end
  end

  // Flash error: one-cycle reset request and a sticky flag
  // Debug denials never get here; they are dropped without a reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_reg  <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      err_reg  <= fw_err || c_deny;
      flag_reg <= flag_reg || fw_err || c_deny;
    end
  end

  // Debug read data is gated a cycle late, in step with the registered store read
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_data_o  <= 8'h00;
      dbg_data_o   <= 8'h00;
      dbg_rd_reg   <= 1'b0;
      dbg_deny_reg <= 1'b0;
    end else begin
      code_data_o  <= store_rdata;
      dbg_rd_reg   <= dreq_i.rd && idle && !lock_load_reg;
      dbg_deny_reg <= d_deny;
      if (dbg_rd_reg) begin
        dbg_data_o <= dbg_deny_reg ? 8'h00 : store_rdata;
      end
    end
  end

  // Outputs
  // Stall is combinational so the core cannot issue again in the accept cycle
  assign external_data_ram_wr_o                = xreq_i.wr && !we_bit;
  assign external_data_ram_rd_o                = xreq_i.rd;
  assign stall_o                  = !idle || fw_go;
  assign store_control_register_o = ctrl_reg;
  assign key_open_o               = unlocked;
  assign key_barred_o             = (key_reg == fpeg_pkg::FPEG_KEY_BARRED);
  assign flash_error_reset_o      = err_reg;
  assign flash_error_flag_o       = flag_reg;
endmodule

// file: core/fpeg_pkg.sv
// Package for the flash program/erase guard: constants and carrier structs.
// Assumes a 16 KiB byte-wide program store in 512-byte pages.
package fpeg_pkg;

  localparam int          ADDR_W           = 14;
  localparam int          PAGE_W           = 5;
  localparam int          PAGE_LSB         = 9;
  localparam int          PAGE_MSB         = 13;
  localparam int          PAGE_BYTES       = 512;
  localparam logic [7:0]  KEY_FIRST        = 8'hA5;
  localparam logic [7:0]  KEY_SECOND       = 8'hF1;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam logic [13:0] USER_TOP         = 14'h3DFF;
  localparam logic [13:0] LOCK_BYTE_ADDR   = 14'h3DFF;
  localparam logic [4:0]  RESERVED_PAGE    = 5'h1F;
  localparam logic [4:0]  LOCK_BYTE_PAGE   = 5'h1E;
  localparam logic [7:0]  LOCK_BYTE_RESET  = 8'hFF;
  localparam int          WSEL_BIT         = 0;
  localparam int          ESEL_BIT         = 1;
  localparam logic [1:0]  STORE_CTRL_RESET = 2'h0;
  localparam int          CLK_MHZ          = 10;
  localparam int          WRITE_TIME_US    = 40;
  localparam int          ERASE_TIME_MS    = 10;
  localparam int          WRITE_CYCLES     = WRITE_TIME_US * CLK_MHZ;
  localparam int          ERASE_CYCLES     = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W            = 20;

  typedef enum logic [1:0] {
    FPEG_KEY_IDLE   = 2'b00,
    FPEG_KEY_HALF   = 2'b01,
    FPEG_KEY_OPEN   = 2'b10,
    FPEG_KEY_BARRED = 2'b11
  } fpeg_key_type;

  typedef enum logic [1:0] {
    FPEG_OP_IDLE  = 2'b00,
    FPEG_OP_WRITE = 2'b01,
    FPEG_OP_ERASE = 2'b10
  } fpeg_op_type;

  // External-move request from the core
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fpeg_xreq_type;

  // Debug port store request
  typedef struct packed {
    logic              wr;
    logic              erase;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fpeg_dreq_type;

endpackage

// file: core/fpeg_store.sv
// Byte-wide program store with registered read data.
// Separate write and read ports; a write and a read can happen in the same cycle.
`timescale 1ns/1ns
module fpeg_store (
  // Clock
  input  wire logic                       clock_i,
  // Access
  input  wire logic                       we_i,
  input  wire logic [fpeg_pkg::ADDR_W-1:0] waddr_i,
  input  wire logic [7:0]                 wdata_i,
  input  wire logic [fpeg_pkg::ADDR_W-1:0] raddr_i,
  output logic      [7:0]                 rdata_o
);
  // Starts erased, as a blank part would
  logic [7:0] mem [0:(1<<fpeg_pkg::ADDR_W)-1] = '{default: fpeg_pkg::ERASED_BYTE};

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// file: verification/fpeg_guard_monitor.sv
// Checker on the guard ports: steering, key gating, error and stall timing.
// Bound into every fpeg_guard; the stall counter assumes ops under 4096 cycles.
`timescale 1ns/1ns
module fpeg_guard_monitor #(
  parameter int ERASE_CYCLES = 50
) (
  // Watched ports
  input wire logic                    clock_i,
  input wire logic                    rst_b_i,
  input wire fpeg_pkg::fpeg_xreq_type xreq_i,
  input wire logic [1:0]              store_control_register_o,
  input wire logic                    key_open_o,
  input wire logic                    key_barred_o,
  input wire logic                    stall_o,
  input wire logic                    flash_error_reset_o,
  input wire logic                    flash_error_flag_o,
  input wire logic                    external_data_ram_wr_o,
  input wire logic                    external_data_ram_rd_o
);
  localparam int WMIN = fpeg_pkg::WRITE_CYCLES;
  localparam int EMIN = ERASE_CYCLES + fpeg_pkg::PAGE_BYTES;
  logic [11:0] cnt_reg;
  logic        ers_reg;
  wire         wen = store_control_register_o[0];
  wire         hit = xreq_i.wr && wen && key_open_o && !stall_o;
  // Op kind is latched only while idle, since the core cannot touch control mid-op
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 12'h000;
      ers_reg <= 1'b0;
    end else begin
      cnt_reg <= stall_o ? cnt_reg + 12'h001 : 12'h000;
      ers_reg <= stall_o ? ers_reg : store_control_register_o[1];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_rd_ram; xreq_i.rd |-> external_data_ram_rd_o; endproperty
  a_rd_ram: assert property (p_rd_ram) else $error("move read not sent to RAM");
  property p_steer; xreq_i.wr |-> external_data_ram_wr_o == !wen; endproperty
  a_steer: assert property (p_steer) else $error("move write steered wrongly");
  property p_gate; $rose(stall_o) && xreq_i.wr |-> key_open_o && wen; endproperty
  a_gate: assert property (p_gate) else $error("op started without key");
  property p_relock; $rose(stall_o) && xreq_i.wr |=> !key_open_o; endproperty
  a_relock: assert property (p_relock) else $error("key stayed open");
  property p_drop; key_barred_o && xreq_i.wr |-> !stall_o; endproperty
  a_drop: assert property (p_drop) else $error("barred write started");
  property p_high; hit && xreq_i.addr > fpeg_pkg::USER_TOP |=> flash_error_reset_o; endproperty
  a_high: assert property (p_high) else $error("no error reset above user top");
  property p_flag; flash_error_reset_o |=> flash_error_flag_o; endproperty
  a_flag: assert property (p_flag) else $error("error flag not set");
  property p_keep; flash_error_flag_o |=> flash_error_flag_o; endproperty
  a_keep: assert property (p_keep) else $error("error flag dropped");
  property p_len; $fell(stall_o) |-> (ers_reg ? (cnt_reg >= EMIN && cnt_reg <= EMIN + 4)
    : (cnt_reg >= WMIN && cnt_reg <= WMIN + 4)); endproperty
  a_len: assert property (p_len) else $error("stall length wrong");
  property p_cap; stall_o |-> cnt_reg < 12'h2BC; endproperty
  a_cap: assert property (p_cap) else $error("stall too long");
endmodule
bind fpeg_guard fpeg_guard_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) u_monitor (.clock_i, .rst_b_i,
  .xreq_i, .store_control_register_o, .key_open_o, .key_barred_o, .stall_o,
  .flash_error_reset_o, .flash_error_flag_o, .external_data_ram_wr_o, .external_data_ram_rd_o);

// file: verification/fpeg_core_model.sv
// Core-side model: unlock-register and store-control writes, external-move reads and writes.
// Each request lasts one clock and is launched just after a rising edge.
`timescale 1ns/1ns
module fpeg_core_model (
  // Clock and stall
  input  wire logic               clock_i,
  input  wire logic               stall_i,
  // Requests
  output logic                    key_wr_o,
  output logic [7:0]              key_data_o,
  output logic                    ctrl_wr_o,
  output logic [1:0]              ctrl_data_o,
  output fpeg_pkg::fpeg_xreq_type xreq_o,
  // Raised when a stall outlasts the wait bound
  output logic                    stuck_o
);
  initial begin
    key_wr_o = 1'b0;
    key_data_o = 8'h00;
    ctrl_wr_o = 1'b0;
    ctrl_data_o = 2'h0;
    xreq_o = '0;
    stuck_o = 1'b0;
  end
  // Idle data is inverted so a stale byte never looks like a fresh one
  task automatic key(input logic [7:0] v);
    @(posedge clock_i);
    key_wr_o <= 1'b1;
    key_data_o <= v;
    @(posedge clock_i);
    key_wr_o <= 1'b0;
    key_data_o <= ~v;
  endtask
  task automatic unlock(input int gap);
    key(fpeg_pkg::KEY_FIRST);
    repeat (gap) @(posedge clock_i);
    key(fpeg_pkg::KEY_SECOND);
  endtask
  task automatic ctrl(input logic [1:0] c);
    @(posedge clock_i);
    ctrl_wr_o <= 1'b1;
    ctrl_data_o <= c;
    @(posedge clock_i);
    ctrl_wr_o <= 1'b0;
    ctrl_data_o <= ~c;
  endtask
  // A stalled core issues nothing; bounded so a stuck stall cannot hang here
  task automatic move(input logic w, input logic r, input logic [13:0] a, input logic [7:0] d);
    for (int i = 0; i < 1000 && stall_i; i++) @(negedge clock_i);
    stuck_o <= stall_i;
    @(posedge clock_i);
    xreq_o <= '{w, r, a, d};
    @(posedge clock_i);
    xreq_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// file: verification/fpeg_guard_test.sv
// Bench for the flash guard: core model, byte-store model and checker.
// Assumes the program store powers up erased with no page locked.
`timescale 1ns/1ns
module fpeg_guard_test;
  logic                    clock_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  logic                    code_rd = 1'b0;
  logic [13:0]             code_addr = 14'h0000;
  logic                    vdd_en = 1'b1;
  logic                    key_wr, ctrl_wr, external_data_ram_wr, external_data_ram_rd, key_open, key_barred, stall;
  logic                    err_rst, err_flag;
  logic [7:0]              key_data, code_data;
  logic [1:0]              ctrl_data, scr, ctl_m;
  fpeg_pkg::fpeg_xreq_type xreq;
  logic [7:0]              mem [16384];
  logic [13:0]             a;
  logic [7:0]              d, dbg_data;
  logic                    stuck;
  fpeg_pkg::fpeg_dreq_type dreq = '0;
  int                      n_errors, n_checks, n_pulse;
  localparam int           ERS = 50;
  always #50 clock_i = ~clock_i;
  fpeg_core_model core (.clock_i, .stall_i(stall), .key_wr_o(key_wr), .key_data_o(key_data),
    .ctrl_wr_o(ctrl_wr), .ctrl_data_o(ctrl_data), .xreq_o(xreq), .stuck_o(stuck));
  fpeg_guard #(.ERASE_CYCLES(ERS)) dut (.clock_i, .rst_b_i, .key_wr_i(key_wr),
    .key_data_i(key_data), .ctrl_wr_i(ctrl_wr), .ctrl_data_i(ctrl_data), .xreq_i(xreq),
    .code_rd_i(code_rd), .code_addr_i(code_addr), .exec_addr_i(14'h0000),
    .code_data_o(code_data), .external_data_ram_wr_o(external_data_ram_wr), .external_data_ram_rd_o(external_data_ram_rd), .dreq_i(dreq),
    .dbg_data_o(dbg_data), .vdd_mon_en_i(vdd_en), .vdd_rst_sel_i(1'b1),
    .store_control_register_o(scr), .key_open_o(key_open), .key_barred_o(key_barred),
    .stall_o(stall), .flash_error_reset_o(err_rst), .flash_error_flag_o(err_flag));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(negedge clock_i) begin
    if (rst_b_i && xreq.rd === 1'b1) chk1(external_data_ram_rd, 1'b1, "ram read");
    if (rst_b_i && xreq.wr === 1'b1) chk1(external_data_ram_wr, ~ctl_m[0], "ram write");
  end
  always @(posedge clock_i) if (err_rst === 1'b1) n_pulse++;
  always @(posedge stuck) begin
    n_errors++;
    $display("[FAIL] %0t core stuck behind stall", $time);
    end_of_test();
  end
  task automatic do_reset;
    rst_b_i <= 1'b0;
    ctl_m = 2'h0;
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk1(key_barred, 1'b0, "barred after reset");
  endtask
  task automatic set_ctrl(input logic [1:0] c);
    core.ctrl(c);
    ctl_m = c;
    @(negedge clock_i);
    chk({6'h00, scr}, {6'h00, c}, "store control");
  endtask
  task automatic open_key;
    core.unlock($urandom_range(32'h0000_0009));
    @(negedge clock_i);
    chk1(key_open, 1'b1, "key open");
  endtask
  task automatic rd_code(input logic [13:0] ad, input string m);
    @(posedge clock_i);
    code_rd <= 1'b1;
    code_addr <= ad;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk(code_data, mem[ad], m);
    @(posedge clock_i);
    code_rd <= 1'b0;
  endtask
  // Bounded wait for the op to end; its length is fixed by the internal timer
  task automatic wait_op(input int exp);
    int i;
    i = 0;
    while (stall !== 1'b0 && i < 2000) begin
      @(negedge clock_i);
      i++;
    end
    if (i == 2000) begin
      n_errors++;
      $display("[FAIL] %0t stall stuck", $time);
      end_of_test();
    end
    chk1(i >= exp - 4 && i <= exp + 4, 1'b1, "stall time");
  endtask
  // Debug request lasts one clock; results are looked at after the next edge
  task automatic dbg(input logic [2:0] k, input logic [13:0] ad, input logic [7:0] dd);
    @(posedge clock_i);
    dreq <= '{k[2], k[1], k[0], ad, dd};
    @(posedge clock_i);
    dreq <= '0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Real operations only; refused ones go through the core model directly
  task automatic flash_op(input logic [1:0] c, input logic [13:0] ad, input logic [7:0] d);
    open_key();
    set_ctrl(c);
    core.move(1'b1, 1'b0, ad, d);
    wait_op(c[1] ? ERS + fpeg_pkg::PAGE_BYTES : fpeg_pkg::WRITE_CYCLES);
    chk1(key_open, 1'b0, "relock");
    set_ctrl(2'h0);
  endtask
  task automatic prog(input logic [13:0] ad, input logic [7:0] d);
    flash_op(2'h1, ad, d);
    mem[ad] = mem[ad] & d;
    rd_code(ad, "program");
  endtask
  initial begin
    n_errors = 0;
    n_checks = 0;
    n_pulse = 0;
    void'($urandom(35));
    foreach (mem[i]) mem[i] = 8'hFF;
    do_reset();
    for (int k = 0; k < 3; k++) begin
      a = 14'($urandom_range(32'h0000_3BFF));
      prog(a, 8'($urandom));
      prog(a, 8'($urandom));
    end
    flash_op(2'h3, a, 8'($urandom));
    for (int i = 0; i < 512; i++) mem[{a[13:9], 9'h000} + 14'(i)] = 8'hFF;
    rd_code({a[13:9], 9'h000}, "erase base");
    rd_code({a[13:9], 9'h1FF}, "erase top");
    rd_code(a, "erase addr");
    prog(a, 8'($urandom));
    $display("test program and erase done");
    set_ctrl(2'h0);
    core.move(1'b1, 1'b0, a, 8'($urandom));
    set_ctrl(2'h1);
    core.move(1'b0, 1'b1, a, 8'h00);
    core.move(1'b1, 1'b0, a, 8'h00);
    @(negedge clock_i);
    chk1(key_barred, 1'b1, "early write bars");
    rd_code(a, "early write dropped");
    set_ctrl(2'h0);
    do_reset();
    $display("test steering done");
    for (int j = 0; j < 2; j++) begin
      core.key(j ? fpeg_pkg::KEY_SECOND : 8'h5A);
      core.unlock(0);
      @(negedge clock_i);
      chk1(key_barred, 1'b1, "bad key bars");
      set_ctrl(2'h1);
      core.move(1'b1, 1'b0, a, 8'h00);
      rd_code(a, "barred write dropped");
      do_reset();
    end
    $display("test bad key done");
    @(posedge clock_i);
    vdd_en <= 1'b0;
    repeat (3) @(posedge clock_i);
    open_key();
    set_ctrl(2'h1);
    core.move(1'b1, 1'b0, a, 8'h00);
    repeat (3) @(negedge clock_i);
    chk(8'(n_pulse), 8'h01, "supply error reset");
    chk1(err_flag, 1'b1, "error flag");
    rd_code(a, "supply write dropped");
    @(posedge clock_i);
    vdd_en <= 1'b1;
    do_reset();
    $display("test supply done");
    open_key();
    set_ctrl(2'h1);
    core.move(1'b1, 1'b0, {5'h1F, 9'($urandom)}, 8'h00);
    repeat (3) @(negedge clock_i);
    chk(8'(n_pulse), 8'h02, "reserved page error");
    do_reset();
    $display("test reserved page done");
    d = 8'($urandom);
    dbg(3'h4, a, d);
    mem[a] = mem[a] & d;
    wait_op(fpeg_pkg::WRITE_CYCLES);
    rd_code(a, "debug program");
    dbg(3'h1, a, 8'h00);
    chk(dbg_data, mem[a], "debug read");
    dbg(3'h4, {5'h1F, 9'($urandom)}, 8'h00);
    chk1(stall, 1'b0, "debug reserved ignored");
    chk(8'(n_pulse), 8'h02, "debug no error reset");
    dbg(3'h4, fpeg_pkg::LOCK_BYTE_ADDR, 8'hFE);
    mem[fpeg_pkg::LOCK_BYTE_ADDR] = mem[fpeg_pkg::LOCK_BYTE_ADDR] & 8'hFE;
    wait_op(fpeg_pkg::WRITE_CYCLES);
    do_reset();
    dbg(3'h1, 14'h0200, 8'h00);
    chk(dbg_data, mem[14'h0200], "open page read");
    dbg(3'h1, 14'h0010, 8'h00);
    chk(dbg_data, 8'h00, "locked page read");
    dbg(3'h4, 14'h0010, 8'h00);
    chk1(stall, 1'b0, "locked write ignored");
    do_reset();
    $display("test debug port done");
    end_of_test();
  end
endmodule
